// [src/edge_event_gen.sv]
`timescale 1ns/1ps
// turns each source level into an activation and a reset pulse
module edge_event_gen #(
  parameter int NSRC = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // synchronised source levels
  input wire logic [NSRC-1:0] levelIn,
  // pulses, two per source: even index activation, odd index reset
  output logic [2*NSRC-1:0] evtPulse
);
  logic [NSRC-1:0] prev_r;

  // at least one source, else the pulse vector is empty
  if (NSRC < 1) begin : gRange
    $error("edge_event_gen: no sources");
  end

  // remember last level; reset assumes all inactive
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prev_r <= '0;
    end else begin
      prev_r <= levelIn;
    end
  end

  // activation takes the lower weight of each pair
  for (genvar i = 0; i < NSRC; i++) begin : gPair
    assign evtPulse[2*i] = levelIn[i] & ~prev_r[i];
    assign evtPulse[2*i+1] = ~levelIn[i] & prev_r[i];
  end
endmodule // edge_event_gen

// [src/event_code_picker.sv]
`timescale 1ns/1ps
// holds pending enabled events and hands out the lowest code first
module event_code_picker #(
  parameter int NEVT = 40
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // new enabled events this cycle
  input wire logic [NEVT-1:0] newEvt,
  // consumer pops current code
  input wire logic pop,
  // current code, 1-based, and its validity
  output logic [5:0] code,
  output logic codeValid
);
  logic [NEVT-1:0] pend_r;
  logic [NEVT-1:0] popMask;
  logic [5:0] idx;

  // codes are six bits and one-based, so at most 63 events
  if (NEVT < 1 || NEVT > 63) begin : gRange
    $error("event_code_picker: event count out of range");
  end

  // priority encoder, lowest index wins
  always_comb begin
    idx = '0;
    for (int i = NEVT - 1; i >= 0; i--) begin
      if (pend_r[i]) idx = 6'(i);
    end
  end

  assign codeValid = |pend_r;
  assign code = idx + event_mask_pkg::FIRST_CODE;
  assign popMask = (pop && codeValid) ? (NEVT'(1) << idx) : '0;

  // new events win over the pop of the same bit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~popMask) | newEvt;
    end
  end
endmodule // event_code_picker

// [src/event_mask_pkg.sv]
package event_mask_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [7:0] HV_MASK_ADDR = 8'h00;
  localparam logic [7:0] LV_MASK_ADDR = 8'h04;
  localparam logic [7:0] CTL_MASK_ADDR = 8'h08;
  localparam logic [7:0] OUTA_MASK_ADDR = 8'h0c;
  localparam logic [7:0] OUTB_MASK_ADDR = 8'h10;
  localparam logic [7:0] EVT_CODE_ADDR = 8'h14;
  localparam logic [7:0] EVT_STAT_ADDR = 8'h18;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h1c;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h20;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h24;
  localparam logic [7:0] LEVEL_ADDR = 8'h28;

  // ==========================================================
  // mask widths and reset values
  // ==========================================================
  localparam int HV_W = 6;
  localparam int LV_W = 8;
  localparam int CTL_W = 10;
  localparam int OUT_W = 8;
  localparam logic [HV_W-1:0] HV_RST = 6'h05;
  localparam logic [LV_W-1:0] LV_RST = 8'h05;
  localparam logic [CTL_W-1:0] CTL_RST = 10'h000;
  localparam logic [OUT_W-1:0] OUTA_RST = 8'h0c;
  localparam logic [OUT_W-1:0] OUTB_RST = 8'h00;

  // ==========================================================
  // event numbering: codes 1..40, groups contiguous
  // ==========================================================
  localparam int NUM_EVT = 40;
  localparam int NUM_SRC = NUM_EVT / 2;
  localparam logic [5:0] FIRST_CODE = 6'h01;

  // ==========================================================
  // interrupt status bits
  // ==========================================================
  localparam int IRQ_W = 2;
  localparam int IRQ_EVT_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;

  typedef enum logic [1:0] {
    HTRANS_IDLE = 2'b00,
    HTRANS_BUSY = 2'b01,
    HTRANS_NONSEQ = 2'b10,
    HTRANS_SEQ = 2'b11
  } htrans_t;

endpackage

// [src/event_report_mask_logic.sv]
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - every activation and reset of each source gets its own code 1..40.
// - enabled event codes queue for reading by the station over the bus.
// - an event is reported only while its mask bit is one.
// - mask bit weights are powers of two in event order.
// - first mask: six high-voltage events, 6 bits, resets to 5.
// - second mask: low-voltage events plus breaker failure, 8 bits, resets to 5.
// - third mask: five control inputs, ten events, 10 bits, resets to 0.
// - each control input makes an activation and a separate reset event.
// - fourth mask: first two start and trip outputs, resets to 12.
module event_report_mask_logic (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // high-voltage stage levels
  input wire logic hvStart,
  input wire logic hvOperate,
  input wire logic hvHarmBlock,
  // low-voltage stage levels
  input wire logic lvStart,
  input wire logic lvOperate,
  input wire logic lvHarmBlock,
  input wire logic breakerFailureGuard,
  // external control input pins
  input wire logic [4:0] extControlIn,
  // start and trip output signals 1..4, order s1 t1 s2 t2 s3 t3 s4 t4
  input wire logic [7:0] outSignal,
  // interrupt
  output logic irq
);
  // ==========================================================
  // source synchronisers
  // ==========================================================
  localparam int NS = event_mask_pkg::NUM_SRC;
  localparam int NE = event_mask_pkg::NUM_EVT;
  logic [NS-1:0] rawSrc;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NE-1:0] evtPulse;
  logic [NE-1:0] maskAll;
  logic [NE-1:0] enabledEvt;

  // sources ordered as event pairs in code order
  assign rawSrc = {outSignal, extControlIn, breakerFailureGuard, lvHarmBlock,
                   lvOperate, lvStart, hvHarmBlock, hvOperate, hvStart};

  // two flip-flops before any logic; sources only observed, not altered
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= rawSrc;
      sync2_r <= sync1_r;
    end
  end

  edge_event_gen #(.NSRC(NS)) uEdge (
    .core_clk(core_clk),
    .rstn(rstn),
    .levelIn(sync2_r),
    .evtPulse(evtPulse)
  );

  // ==========================================================
  // elaboration checks
  // ==========================================================
  // the five mask fields must tile the event vector exactly
  if (event_mask_pkg::HV_W + event_mask_pkg::LV_W + event_mask_pkg::CTL_W +
      2 * event_mask_pkg::OUT_W != NE) begin : gMaskTile
    $error("event_report_mask_logic: mask widths do not cover the events");
  end
  // two events per source, and the level word must fit one bus word
  if (2 * NS != NE || NS > 32) begin : gSrcPair
    $error("event_report_mask_logic: source count does not match the events");
  end
  // the highest code must still fit the six-bit code field
  if (NE + int'(event_mask_pkg::FIRST_CODE) > 64) begin : gCodeFit
    $error("event_report_mask_logic: event codes exceed six bits");
  end

  // ==========================================================
  // mask registers
  // ==========================================================
  logic [event_mask_pkg::HV_W-1:0] hvMask_r;
  logic [event_mask_pkg::LV_W-1:0] lvMask_r;
  logic [event_mask_pkg::CTL_W-1:0] ctlMask_r;
  logic [event_mask_pkg::OUT_W-1:0] outAMask_r;
  logic [event_mask_pkg::OUT_W-1:0] outBMask_r;
  logic [event_mask_pkg::IRQ_W-1:0] irqStat_r;
  logic [event_mask_pkg::IRQ_W-1:0] irqEn_r;
  logic overflowFlag;

  // bit n of each mask has weight 2**n, in event order
  assign maskAll = {outBMask_r, outAMask_r, ctlMask_r, lvMask_r, hvMask_r};
  // suppressed events are dropped here and nowhere else
  assign enabledEvt = evtPulse & maskAll;

  // ==========================================================
  // ahb-lite address phase capture
  // ==========================================================
  logic dphWr_r;
  logic [7:0] dphAddr_r;
  logic addrOk;
  logic acceptPhase;

  function automatic logic isMapped(input logic [31:0] a);
    isMapped = (a[1:0] == 2'b00) && (a[31:8] == 24'h000000) &&
               (a[7:0] <= event_mask_pkg::LEVEL_ADDR);
  endfunction

  assign acceptPhase = hsel && hready && (htrans == event_mask_pkg::HTRANS_NONSEQ ||
                       htrans == event_mask_pkg::HTRANS_SEQ);
  assign addrOk = isMapped(haddr);

  // latch one transfer for its data phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dphWr_r <= 1'b0;
      dphAddr_r <= 8'h00;
    end else begin
      dphWr_r <= acceptPhase && hwrite && addrOk;
      dphAddr_r <= acceptPhase ? haddr[7:0] : dphAddr_r;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // mask register writes
  // ==========================================================
  // data phase write aimed at one register of the map
  function automatic logic wrSel(input logic wr, input logic [7:0] a,
                                 input logic [7:0] target);
    wrSel = wr && (a == target);
  endfunction

  // high-voltage stage mask, low bits of the word only
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hvMask_r <= event_mask_pkg::HV_RST;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::HV_MASK_ADDR)) begin
      hvMask_r <= hwdata[event_mask_pkg::HV_W-1:0];
    end
  end

  // low-voltage stage and breaker failure mask
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lvMask_r <= event_mask_pkg::LV_RST;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::LV_MASK_ADDR)) begin
      lvMask_r <= hwdata[event_mask_pkg::LV_W-1:0];
    end
  end

  // control input mask, ten events
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctlMask_r <= event_mask_pkg::CTL_RST;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::CTL_MASK_ADDR)) begin
      ctlMask_r <= hwdata[event_mask_pkg::CTL_W-1:0];
    end
  end

  // first output group mask, trip one events open after reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      outAMask_r <= event_mask_pkg::OUTA_RST;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::OUTA_MASK_ADDR)) begin
      outAMask_r <= hwdata[event_mask_pkg::OUT_W-1:0];
    end
  end

  // second output group mask
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      outBMask_r <= event_mask_pkg::OUTB_RST;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::OUTB_MASK_ADDR)) begin
      outBMask_r <= hwdata[event_mask_pkg::OUT_W-1:0];
    end
  end

  // ==========================================================
  // event code queue
  // ==========================================================
  logic [5:0] evtCode;
  logic evtValid;
  logic codePop;

  // reading the code register consumes the code on show
  assign codePop = acceptPhase && !hwrite &&
                   (haddr[7:0] == event_mask_pkg::EVT_CODE_ADDR) && addrOk;

  event_code_picker #(.NEVT(NE)) uPick (
    .core_clk(core_clk),
    .rstn(rstn),
    .newEvt(enabledEvt),
    .pop(codePop),
    .code(evtCode),
    .codeValid(evtValid)
  );

  // overflow: an enabled event arrives while its own code is still pending
  logic [NE-1:0] pendShadow_r;
  logic dupEvt;
  assign dupEvt = |(enabledEvt & pendShadow_r);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pendShadow_r <= '0;
    end else begin
      pendShadow_r <= (pendShadow_r & ~((codePop && evtValid) ?
                      (NE'(1) << (evtCode - event_mask_pkg::FIRST_CODE)) : '0)) | enabledEvt;
    end
  end

  // ==========================================================
  // interrupt status, enable and clear
  // ==========================================================
  logic [event_mask_pkg::IRQ_W-1:0] irqSet;
  logic [event_mask_pkg::IRQ_W-1:0] irqClr;

  always_comb begin
    irqSet = '0;
    irqSet[event_mask_pkg::IRQ_EVT_BIT] = |enabledEvt;
    irqSet[event_mask_pkg::IRQ_OVF_BIT] = dupEvt;
    irqClr = '0;
    if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::IRQ_CLR_ADDR)) begin
      irqClr = hwdata[event_mask_pkg::IRQ_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
    end
  end

  // interrupt enable, same layout as the status bits
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqEn_r <= '0;
    end else if (wrSel(dphWr_r, dphAddr_r, event_mask_pkg::IRQ_EN_ADDR)) begin
      irqEn_r <= hwdata[event_mask_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_r & irqEn_r);

  // overflow flag for the code status word, cleared with the status bit
  assign overflowFlag = irqStat_r[event_mask_pkg::IRQ_OVF_BIT];

  // ==========================================================
  // read data
  // ==========================================================
  logic [31:0] rdNxt;
  logic [31:0] hrdata_r;

  always_comb begin
    rdNxt = 32'h00000000;
    case (haddr[7:0])
      event_mask_pkg::HV_MASK_ADDR: rdNxt[event_mask_pkg::HV_W-1:0] = hvMask_r;
      event_mask_pkg::LV_MASK_ADDR: rdNxt[event_mask_pkg::LV_W-1:0] = lvMask_r;
      event_mask_pkg::CTL_MASK_ADDR: rdNxt[event_mask_pkg::CTL_W-1:0] = ctlMask_r;
      event_mask_pkg::OUTA_MASK_ADDR: rdNxt[event_mask_pkg::OUT_W-1:0] = outAMask_r;
      event_mask_pkg::OUTB_MASK_ADDR: rdNxt[event_mask_pkg::OUT_W-1:0] = outBMask_r;
      event_mask_pkg::EVT_CODE_ADDR: rdNxt[5:0] = evtValid ? evtCode : 6'h00;
      event_mask_pkg::EVT_STAT_ADDR: rdNxt[1:0] = {overflowFlag, evtValid};
      event_mask_pkg::IRQ_STAT_ADDR: rdNxt[event_mask_pkg::IRQ_W-1:0] = irqStat_r;
      event_mask_pkg::IRQ_EN_ADDR: rdNxt[event_mask_pkg::IRQ_W-1:0] = irqEn_r;
      event_mask_pkg::LEVEL_ADDR: rdNxt[NS-1:0] = sync2_r;
      default: rdNxt = 32'h00000000;
    endcase
  end

  // read data sampled at the address phase, held through data phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hrdata_r <= 32'h00000000;
    end else if (acceptPhase && !hwrite) begin
      hrdata_r <= addrOk ? rdNxt : 32'h00000000;
    end
  end

  assign hrdata = hrdata_r;
endmodule // event_report_mask_logic

// [test/event_mask_monitor.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker for the event mask register bank
module event_mask_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // interrupt
  input wire logic irq
);
  logic rdTake;
  logic wrTake;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // transfers taken at this edge
  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  assign wrTake = hsel && hready && htrans[1] && hwrite;
  zero_wait_a: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
  hv_width_a: assert property (rdTake && haddr == 32'h0 |=> hrdata[31:6] == 26'h0)
    else $error("hv mask read too wide");
  lv_width_a: assert property (rdTake && haddr == 32'h4 |=> hrdata[31:8] == 24'h0)
    else $error("lv mask read too wide");
  ctl_width_a: assert property (rdTake && haddr == 32'h8 |=> hrdata[31:10] == 22'h0)
    else $error("control mask read too wide");
  out_width_a: assert property (rdTake && haddr == 32'hc |=> hrdata[31:8] == 24'h0)
    else $error("output mask read too wide");
  unmapped_read_a: assert property (rdTake && haddr > 32'h28 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!rdTake |=> $stable(hrdata))
    else $error("read data moved without a read");
  irq_fall_a: assert property ($fell(irq) |-> $past(wrTake, 2))
    else $error("interrupt dropped without a write");
  // main scenarios
  code_read_c: cover property (rdTake && haddr == 32'h14);
  irq_rise_c: cover property ($rose(irq));
  irq_clear_c: cover property (wrTake && haddr == 32'h24);
  status_read_c: cover property (rdTake && haddr == 32'h18);
endmodule // event_mask_monitor

bind event_report_mask_logic event_mask_monitor mon (.core_clk(core_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// [test/event_report_mask_logic_tb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// bench for the event mask register bank
module event_report_mask_logic_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] rst, wr, exp;} row_t;
  localparam logic [7:0] EVT = event_mask_pkg::EVT_CODE_ADDR;
  localparam logic [7:0] IEN = event_mask_pkg::IRQ_EN_ADDR;
  localparam logic [7:0] ICLR = event_mask_pkg::IRQ_CLR_ADDR;
  localparam logic [7:0] ESTAT = event_mask_pkg::EVT_STAT_ADDR;
  localparam logic [7:0] ISTAT = event_mask_pkg::IRQ_STAT_ADDR;
  localparam logic [7:0] LVL = event_mask_pkg::LEVEL_ADDR;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [19:0] src = 20'h0;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failCount = 0;
  int comparisons = 0;
  // mask rows: reset value, over-range write, kept low bits
  row_t rows[5] = '{'{8'h00, 32'h5, 32'hff, 32'h3f}, '{8'h04, 32'h5, 32'h1ff, 32'hff},
    '{8'h08, 32'h0, 32'hfff, 32'h3ff}, '{8'h0c, 32'hc, 32'h1ff, 32'hff},
    '{8'h10, 32'h0, 32'h1ff, 32'hff}};
  always #2.5 core_clk = ~core_clk;
  assign hready = hreadyout;
  station_bus stn (.core_clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  event_report_mask_logic uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hvStart(src[0]),
    .hvOperate(src[1]), .hvHarmBlock(src[2]), .lvStart(src[3]), .lvOperate(src[4]),
    .lvHarmBlock(src[5]), .breakerFailureGuard(src[6]), .extControlIn(src[11:7]),
    .outSignal(src[19:12]), .irq(irq));
  // comparison and verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bus helpers
  task busOp(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    bit late;
    stn.xfer(w, {24'h0, a}, d, q, late);
    // a bus that never answers ends the run as a failure
    if (late) begin
      failCount++;
      printVerdict;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busOp(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busOp(1'b1, a, d, q);
  endtask
  task setSrc(input int i, input logic v);
    src[i] <= v;
    repeat (6) @(posedge core_clk);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    failCount++;
    printVerdict;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].rst);
      wr(rows[i].a, rows[i].wr);
      rd(rows[i].a, rows[i].exp);
    end
    // every source, activation then reset, all masks open
    for (int i = 0; i < 20; i++) begin
      setSrc(i, 1'b1);
      rd(EVT, 2 * i + 1);
      rd(EVT, 32'h0);
      setSrc(i, 1'b0);
      rd(EVT, 2 * i + 2);
    end
    // of the control events only the first activation enabled; other masks still open
    wr(8'h08, 32'h1);
    wr(ICLR, 32'h3);
    wr(IEN, 32'h1);
    setSrc(7, 1'b1);
    chk({31'h0, irq}, 32'h1);
    wr(IEN, 32'h0);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(IEN, 32'h1);
    wr(ICLR, 32'h1);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    setSrc(7, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(EVT, 32'd15);
    rd(EVT, 32'h0);
    // two events together come out lowest first
    src[0] <= 1'b1;
    src[2] <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(EVT, 32'd1);
    rd(EVT, 32'd5);
    rd(8'h40, 32'h0);
    // sources are only observed: the level word mirrors the pins
    rd(LVL, 32'h5);
    // a reset event repeated while its code is pending flags overflow
    setSrc(0, 1'b0);
    setSrc(0, 1'b1);
    setSrc(0, 1'b0);
    rd(ESTAT, 32'h3);
    rd(ISTAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(ICLR, 32'h3);
    rd(ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(EVT, 32'd1);
    rd(EVT, 32'd2);
    rd(ESTAT, 32'h0);
    // reset in mid-run restores the masks and empties the queue
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(event_mask_pkg::HV_MASK_ADDR, 32'h5);
    rd(event_mask_pkg::OUTA_MASK_ADDR, 32'hc);
    rd(EVT, 32'h0);
    rd(IEN, 32'h0);
    printVerdict;
  end
endmodule // event_report_mask_logic_tb_top

// [test/station_bus.sv]
`timescale 1ns/1ps
// ==========================================================
// ahb-lite master standing in for the station system
module station_bus (
  // clock
  input wire logic core_clk,
  // bus answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // idle bus at time zero, always whole words
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single transfer; late is set when hready never came within the bound
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q,
                      output bit late);
    int n;
    n = 0;
    late = 1'b0;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) late = 1'b1;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) late = 1'b1;
    q = hrdata;
    hwdata <= ~d; // released data is not left showing
  endtask
endmodule // station_bus
